/* core/sensor_power_command_control.sv */
/*
 * Power-command controller of a magnetic sensor, reached over AXI4-Lite.
 * Holds identification, command error, pad drive, rate/averaging, axis
 * enable, command, status and active-setting registers, and drives the
 * sensor core's mode and one-shot action strobes.
 * Assumes a 50 MHz clk, a one-clock design, and a host obeying busy.
 */
`timescale 1ns/1ns
`default_nettype none
module sensor_power_command_control #(
	parameter int CMD_CYCLES = pmu_cmd_pkg::CMD_CYCLES,
	parameter int TIMER_W = 8,
	parameter logic [3:0] IDENT_FIXED = pmu_cmd_pkg::IDENT_FIXED_DEFAULT,
	parameter logic [3:0] IDENT_PROG = pmu_cmd_pkg::IDENT_PROG_DEFAULT
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pmu_cmd_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [pmu_cmd_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic cmdBusy,
	output logic normalMode,
	output logic forcedMode,
	output logic measureStart,
	output logic fluxGuideStart,
	output logic bitResetStart,
	output logic quickRecharge,
	output logic [pmu_cmd_pkg::AXIS_W-1:0] axisEnable,
	output logic [pmu_cmd_pkg::PAD_W-1:0] padDrive,
	output logic [pmu_cmd_pkg::ODR_W-1:0] activeOdr,
	output logic [pmu_cmd_pkg::AVG_W-1:0] activeAvg,
	output logic odrSupported,
	output logic [3:0] avgSamples
);
	if (CMD_CYCLES < pmu_cmd_pkg::REJECT_CYCLES || CMD_CYCLES >= (1 << TIMER_W)) begin : g_bad_cycles
		$error("CMD_CYCLES must fit the timer and not be below the reject time");
	end

	// bus state; address and data channels are held while ready is low
	logic [pmu_cmd_pkg::AXI_ADDR_W-1:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	// register contents
	logic errFlag;
	logic [pmu_cmd_pkg::RATE_W-1:0] rateCfg;
	logic illegalFlag;
	logic odrOverwritten;
	logic avgOverwritten;
	pmu_cmd_pkg::power_mode_t mode;
	pmu_cmd_pkg::power_mode_t next_mode;
	logic timerDone;

	// write and read commit decode
	wire logic wrCommit = clkEn && !awready && !wready && !bvalid;
	wire logic rdCommit = clkEn && arvalid && arready;
	wire logic [5:0] wrIdx = wrAddr[pmu_cmd_pkg::IDX_LSB +: 6];
	wire logic [5:0] rdIdx = araddr[pmu_cmd_pkg::IDX_LSB +: 6];
	wire logic lowLane = wrStrb[0];
	wire logic wrMapped = wrIdx inside {pmu_cmd_pkg::IDX_IDENT, pmu_cmd_pkg::IDX_ERROR, pmu_cmd_pkg::IDX_PAD,
		pmu_cmd_pkg::IDX_RATE, pmu_cmd_pkg::IDX_AXIS, pmu_cmd_pkg::IDX_COMMAND, pmu_cmd_pkg::IDX_STATUS,
		pmu_cmd_pkg::IDX_ACTIVE};
	wire logic rdMapped = rdIdx inside {pmu_cmd_pkg::IDX_IDENT, pmu_cmd_pkg::IDX_ERROR, pmu_cmd_pkg::IDX_PAD,
		pmu_cmd_pkg::IDX_RATE, pmu_cmd_pkg::IDX_AXIS, pmu_cmd_pkg::IDX_COMMAND, pmu_cmd_pkg::IDX_STATUS,
		pmu_cmd_pkg::IDX_ACTIVE};
	wire logic wrLow = wrCommit && lowLane;

	// command decode and acceptance
	wire logic cmdWrite = wrLow && wrIdx == pmu_cmd_pkg::IDX_COMMAND;
	wire logic [3:0] cmdCode = wrData[pmu_cmd_pkg::CMD_W-1:0];
	wire logic codeUndefined = cmdCode > pmu_cmd_pkg::BIT_RESET_QUICK;
	wire logic normalBlocked = mode == pmu_cmd_pkg::MODE_NORMAL && cmdCode != pmu_cmd_pkg::SLEEP_ENTRY
		&& cmdCode != pmu_cmd_pkg::RATE_SETTINGS_APPLY;
	wire logic notPermitted = codeUndefined || normalBlocked;
	wire logic cmdTaken = cmdWrite && !cmdBusy;
	wire logic cmdAccepted = cmdTaken && !notPermitted;
	wire logic cmdRejected = cmdTaken && notPermitted;
	wire logic isForced = cmdCode == pmu_cmd_pkg::FORCED_MEASURE_FULL || cmdCode == pmu_cmd_pkg::FORCED_MEASURE_QUICK;
	wire logic isFlux = cmdCode == pmu_cmd_pkg::FLUX_GUIDE_RESET_FULL || cmdCode == pmu_cmd_pkg::FLUX_GUIDE_RESET_QUICK;
	wire logic isBitReset = cmdCode == pmu_cmd_pkg::BIT_RESET_FULL || cmdCode == pmu_cmd_pkg::BIT_RESET_QUICK;
	wire logic isQuick = cmdCode == pmu_cmd_pkg::FORCED_MEASURE_QUICK || cmdCode == pmu_cmd_pkg::FLUX_GUIDE_RESET_QUICK
		|| cmdCode == pmu_cmd_pkg::BIT_RESET_QUICK;
	wire logic rateApply = cmdAccepted && cmdCode == pmu_cmd_pkg::RATE_SETTINGS_APPLY;
	wire logic [pmu_cmd_pkg::ODR_W-1:0] cfgOdr = rateCfg[pmu_cmd_pkg::ODR_LSB +: pmu_cmd_pkg::ODR_W];
	wire logic [pmu_cmd_pkg::AVG_W-1:0] cfgAvg = rateCfg[pmu_cmd_pkg::AVG_LSB +: pmu_cmd_pkg::AVG_W];
	wire logic [TIMER_W-1:0] timerLoad = notPermitted ? TIMER_W'(pmu_cmd_pkg::REJECT_CYCLES) : TIMER_W'(CMD_CYCLES);

	// command error flag: set wins over read clear and write-one clear
	wire logic errSet = cmdWrite && cmdBusy;
	wire logic errReadClear = rdCommit && rdIdx == pmu_cmd_pkg::IDX_ERROR;
	wire logic errWriteClear = wrLow && wrIdx == pmu_cmd_pkg::IDX_ERROR && wrData[pmu_cmd_pkg::ERR_CMD_BIT];
	wire logic next_errFlag = errSet || (errFlag && !errReadClear && !errWriteClear);

	// read data mux; reserved bits and the write-only command read zero
	logic [7:0] readByte;
	always_comb begin
		readByte = 8'h00;
		case (rdIdx)
			pmu_cmd_pkg::IDX_IDENT: readByte = {IDENT_FIXED, IDENT_PROG};
			pmu_cmd_pkg::IDX_ERROR: readByte[pmu_cmd_pkg::ERR_CMD_BIT] = errFlag;
			pmu_cmd_pkg::IDX_PAD: readByte[pmu_cmd_pkg::PAD_W-1:0] = padDrive;
			pmu_cmd_pkg::IDX_RATE: readByte[pmu_cmd_pkg::RATE_W-1:0] = rateCfg;
			pmu_cmd_pkg::IDX_AXIS: readByte[pmu_cmd_pkg::AXIS_W-1:0] = axisEnable;
			pmu_cmd_pkg::IDX_STATUS: begin
				readByte[pmu_cmd_pkg::ST_BUSY_BIT] = cmdBusy;
				readByte[pmu_cmd_pkg::ST_ODRW_BIT] = odrOverwritten;
				readByte[pmu_cmd_pkg::ST_AVGW_BIT] = avgOverwritten;
				readByte[pmu_cmd_pkg::ST_NORMAL_BIT] = normalMode;
				readByte[pmu_cmd_pkg::ST_ILLEGAL_BIT] = illegalFlag;
			end
			pmu_cmd_pkg::IDX_ACTIVE: readByte = {2'h0, activeAvg, activeOdr};
			default: readByte = 8'h00;
		endcase
	end

	// power mode sequencing
	always_comb begin
		next_mode = mode;
		case (mode)
			pmu_cmd_pkg::MODE_SUSPEND, pmu_cmd_pkg::MODE_NORMAL, pmu_cmd_pkg::MODE_FORCED: begin
				if (mode == pmu_cmd_pkg::MODE_FORCED && timerDone) begin
					next_mode = pmu_cmd_pkg::MODE_SUSPEND; // single shot returns to suspend
				end
				if (cmdAccepted && cmdCode == pmu_cmd_pkg::SLEEP_ENTRY) begin
					next_mode = pmu_cmd_pkg::MODE_SUSPEND;
				end else if (cmdAccepted && cmdCode == pmu_cmd_pkg::NORMAL_MODE_ENTRY) begin
					next_mode = pmu_cmd_pkg::MODE_NORMAL;
				end else if (cmdAccepted && isForced) begin
					next_mode = pmu_cmd_pkg::MODE_FORCED;
				end
			end
			default: next_mode = pmu_cmd_pkg::MODE_SUSPEND;
		endcase
	end

	// busy timing for every taken command, short for a rejected one
	cmd_timer #(
		.WIDTH(TIMER_W)
	) u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.load(cmdTaken),
		.loadValue(timerLoad),
		.busy(cmdBusy),
		.done(timerDone)
	);

	// write channel handshakes and response
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= pmu_cmd_pkg::RESP_OKAY;
			wrAddr <= '0;
			wrData <= '0;
			wrStrb <= '0;
		end else if (clkEn) begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wrAddr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wrData <= wdata;
				wrStrb <= wstrb;
			end
			if (wrCommit) begin
				bvalid <= 1'b1;
				bresp <= wrMapped ? pmu_cmd_pkg::RESP_OKAY : pmu_cmd_pkg::RESP_DECERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// read channel: one cycle from address to data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= pmu_cmd_pkg::RESP_OKAY;
		end else if (clkEn) begin
			if (rdCommit) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h000000, readByte};
				rresp <= rdMapped ? pmu_cmd_pkg::RESP_OKAY : pmu_cmd_pkg::RESP_DECERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// configuration registers, low byte lane only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			padDrive <= pmu_cmd_pkg::PAD_RESET;
			rateCfg <= pmu_cmd_pkg::RATE_RESET;
			axisEnable <= pmu_cmd_pkg::AXIS_RESET;
			errFlag <= 1'b0;
		end else if (clkEn) begin
			if (wrLow && wrIdx == pmu_cmd_pkg::IDX_PAD) padDrive <= wrData[pmu_cmd_pkg::PAD_W-1:0];
			if (wrLow && wrIdx == pmu_cmd_pkg::IDX_RATE) rateCfg <= wrData[pmu_cmd_pkg::RATE_W-1:0];
			if (wrLow && wrIdx == pmu_cmd_pkg::IDX_AXIS) axisEnable <= wrData[pmu_cmd_pkg::AXIS_W-1:0];
			errFlag <= next_errFlag;
		end
	end

	// command effects: mode, strobes, active rate settings, status flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= pmu_cmd_pkg::MODE_SUSPEND;
			normalMode <= 1'b0;
			forcedMode <= 1'b0;
			measureStart <= 1'b0;
			fluxGuideStart <= 1'b0;
			bitResetStart <= 1'b0;
			quickRecharge <= 1'b0;
			illegalFlag <= 1'b0;
			activeOdr <= pmu_cmd_pkg::RATE_RESET[pmu_cmd_pkg::ODR_LSB +: pmu_cmd_pkg::ODR_W];
			activeAvg <= pmu_cmd_pkg::RATE_RESET[pmu_cmd_pkg::AVG_LSB +: pmu_cmd_pkg::AVG_W];
			odrSupported <= 1'b1;
			avgSamples <= 4'h2;
			odrOverwritten <= 1'b0;
			avgOverwritten <= 1'b0;
		end else if (clkEn) begin
			mode <= next_mode;
			normalMode <= next_mode == pmu_cmd_pkg::MODE_NORMAL;
			forcedMode <= next_mode == pmu_cmd_pkg::MODE_FORCED;
			measureStart <= cmdAccepted && isForced;
			fluxGuideStart <= cmdAccepted && isFlux;
			bitResetStart <= cmdAccepted && isBitReset;
			if (cmdAccepted && (isForced || isFlux || isBitReset)) quickRecharge <= isQuick;
			if (cmdRejected) illegalFlag <= 1'b1;
			else if (cmdAccepted) illegalFlag <= 1'b0;
			if (rateApply) begin
				activeOdr <= cfgOdr;
				activeAvg <= cfgAvg;
				odrSupported <= cfgOdr >= pmu_cmd_pkg::ODR_MIN && cfgOdr <= pmu_cmd_pkg::ODR_MAX;
				avgSamples <= 4'h1 << cfgAvg;
				odrOverwritten <= cfgOdr != activeOdr;
				avgOverwritten <= cfgAvg != activeAvg;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_overlap_sets_error: assert property (errSet |=> errFlag && $stable(mode))
		else $error("overlapping command did not flag error");
	a_busy_after_take: assert property (cmdTaken |=> cmdBusy ##1 cmdBusy)
		else $error("busy not raised for taken command");
	a_error_read_clear: assert property (errReadClear && !errSet |=> !errFlag)
		else $error("error flag survived its read");
	a_error_write_clear: assert property (errWriteClear && !errSet |=> !errFlag)
		else $error("error flag survived write of one");
	a_error_keep_zero: assert property (wrLow && wrIdx == pmu_cmd_pkg::IDX_ERROR
		&& !wrData[pmu_cmd_pkg::ERR_CMD_BIT] && errFlag && !errReadClear |=> errFlag)
		else $error("error flag cleared by write of zero");
	a_undefined_code: assert property (cmdTaken && codeUndefined |=> illegalFlag && mode == $past(mode))
		else $error("undefined code changed mode");
	a_normal_blocks: assert property (cmdTaken && normalBlocked |=> illegalFlag && !measureStart
		&& !fluxGuideStart && !bitResetStart && normalMode)
		else $error("command escaped normal mode guard");
	a_forced_strobe: assert property (cmdAccepted && isForced |=> measureStart && forcedMode ##1 !measureStart)
		else $error("forced measure strobe wrong");
	a_rate_apply: assert property (rateApply |=> activeOdr == $past(cfgOdr) && activeAvg == $past(cfgAvg))
		else $error("rate settings not applied");
	a_ident_read: assert property (rdCommit && rdIdx == pmu_cmd_pkg::IDX_IDENT
		|=> rdata == {24'h000000, IDENT_FIXED, IDENT_PROG})
		else $error("identification read wrong");
	a_reserved_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("reserved read bits not zero");

	c_forced_run: cover property (cmdAccepted && isForced ##[1:300] timerDone);
	c_overlap: cover property (errSet);
	c_rate_apply: cover property (rateApply);
	c_illegal_normal: cover property (cmdTaken && normalBlocked);
endmodule // sensor_power_command_control
`default_nettype wire

/* core/pmu_cmd_pkg.sv */
/*
 * Constants for the sensor power-command controller: register indices,
 * field positions, reset values, command and mode codes, timing figures.
 * Assumes a 50 MHz clock and an AXI4-Lite register bus with 32-bit data.
 */
package pmu_cmd_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_IDENT = 6'h00;
	localparam logic [5:0] IDX_ERROR = 6'h02;
	localparam logic [5:0] IDX_PAD = 6'h03;
	localparam logic [5:0] IDX_RATE = 6'h04;
	localparam logic [5:0] IDX_AXIS = 6'h05;
	localparam logic [5:0] IDX_COMMAND = 6'h06;
	localparam logic [5:0] IDX_STATUS = 6'h07;
	localparam logic [5:0] IDX_ACTIVE = 6'h08;
	localparam int AXI_ADDR_W = 8;
	localparam int IDX_LSB = 2;
	// identification nibbles; values are arbitrary
	localparam logic [3:0] IDENT_FIXED_DEFAULT = 4'h5;
	localparam logic [3:0] IDENT_PROG_DEFAULT = 4'h1;
	// field layout
	localparam int ODR_LSB = 0;
	localparam int ODR_W = 4;
	localparam int AVG_LSB = 4;
	localparam int AVG_W = 2;
	localparam int RATE_W = 6;
	localparam int PAD_W = 3;
	localparam int AXIS_W = 3;
	localparam int CMD_W = 4;
	localparam int ERR_CMD_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ODRW_BIT = 1;
	localparam int ST_AVGW_BIT = 2;
	localparam int ST_NORMAL_BIT = 3;
	localparam int ST_ILLEGAL_BIT = 4;
	localparam int ACT_AVG_LSB = 4;
	// reset values and the supported ODR range
	localparam logic [PAD_W-1:0] PAD_RESET = 3'h7;
	localparam logic [RATE_W-1:0] RATE_RESET = 6'h14;
	localparam logic [AXIS_W-1:0] AXIS_RESET = 3'h7;
	localparam logic [ODR_W-1:0] ODR_MIN = 4'h2;
	localparam logic [ODR_W-1:0] ODR_MAX = 4'ha;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// command processing times
	localparam int CLK_PERIOD_NS = 20;
	localparam int CMD_TIME_NS = 2000;
	localparam int CMD_CYCLES = (CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REJECT_TIME_NS = 40;
	localparam int REJECT_CYCLES = (REJECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		SLEEP_ENTRY = 4'b0000,
		NORMAL_MODE_ENTRY = 4'b0001,
		RATE_SETTINGS_APPLY = 4'b0010,
		FORCED_MEASURE_FULL = 4'b0011,
		FORCED_MEASURE_QUICK = 4'b0100,
		FLUX_GUIDE_RESET_FULL = 4'b0101,
		FLUX_GUIDE_RESET_QUICK = 4'b0110,
		BIT_RESET_FULL = 4'b0111,
		BIT_RESET_QUICK = 4'b1000
	} power_cmd_t;

	typedef enum logic [1:0] {
		MODE_SUSPEND = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_FORCED = 2'b10
	} power_mode_t;
endpackage

/* core/cmd_timer.sv */
/*
 * Countdown timer that holds a busy level for a loaded number of cycles
 * and pulses done on the edge where busy falls.
 * Assumes the loader never loads while busy is high.
 */
`timescale 1ns/1ns
`default_nettype none
module cmd_timer #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] count;
	wire logic atLast = busy && (count == WIDTH'(1));

	if (WIDTH < 2) begin : g_bad_width
		$error("cmd_timer needs WIDTH of at least 2");
	end

	// count down while busy
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (clkEn) begin
			if (load) begin
				count <= loadValue;
				busy <= 1'b1;
				done <= 1'b0;
			end else begin
				count <= busy ? count - WIDTH'(1) : count;
				busy <= busy && !atLast;
				done <= atLast;
			end
		end
	end

	a_timer_load: assert property (@(posedge clk) disable iff (!rst_b)
		clkEn && load && loadValue > WIDTH'(1) |=> busy && !done)
		else $error("timer not busy after load");
endmodule // cmd_timer
`default_nettype wire

/* verif/host_bus_model.sv */
/*
 * host-side register bus master for the power-command controller bench.
 * assumes one clock; every call first waits for a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
	input wire logic clk,
	output logic awvalid,
	input wire logic awready,
	output logic [pmu_cmd_pkg::AXI_ADDR_W-1:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [pmu_cmd_pkg::AXI_ADDR_W-1:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	output logic hung
);
	// idle bus, nothing offered
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, hung} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
	end

	// one write; address and data offered together, each dropped when taken
	task automatic wr(input logic [5:0] idx, input logic [7:0] val, output logic [1:0] resp);
		bit got;
		got = 0;
		resp = 2'h2;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, val};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 60 && !got; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				resp = bresp;
				bready <= 1'b0;
				got = 1;
			end
		end
		hung |= !got;
		#2;
	endtask

	// one read; rready held until the answer is sampled
	task automatic rd(input logic [5:0] idx, output logic [31:0] data, output logic [1:0] resp);
		bit got;
		got = 0;
		data = '0;
		resp = 2'h2;
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 60 && !got; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				data = rdata;
				resp = rresp;
				rready <= 1'b0;
				got = 1;
			end
		end
		hung |= !got;
		#2;
	endtask
endmodule // host_bus_model
`default_nettype wire

/* verif/sensor_power_command_control_tb_top.sv */
/*
 * self-checking bench for the power-command controller.
 * assumes host_bus_model as bus master and a 50 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sensor_power_command_control_tb_top;
	localparam int CMD_CYC = 12;
	localparam logic [3:0] ID_HI = 4'ha; // arbitrary value
	localparam logic [3:0] ID_LO = 4'h6; // arbitrary value
	logic clk = 1'b0;
	logic rst_b, clkEn, hung, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, activeOdr, avgSamples;
	logic [1:0] bresp, rresp, activeAvg;
	logic cmdBusy, normalMode, forcedMode, measureStart, fluxGuideStart, bitResetStart, quickRecharge, odrSupported;
	logic [2:0] axisEnable, padDrive;
	int failures = 0, n_compared = 0, nMeas = 0, nFlux = 0, nBit = 0;

	sensor_power_command_control #(.CMD_CYCLES(CMD_CYC), .IDENT_FIXED(ID_HI), .IDENT_PROG(ID_LO))
		i_sensor_power_command_control (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.cmdBusy(cmdBusy), .normalMode(normalMode), .forcedMode(forcedMode), .measureStart(measureStart),
		.fluxGuideStart(fluxGuideStart), .bitResetStart(bitResetStart), .quickRecharge(quickRecharge),
		.axisEnable(axisEnable), .padDrive(padDrive), .activeOdr(activeOdr), .activeAvg(activeAvg),
		.odrSupported(odrSupported), .avgSamples(avgSamples));
	host_bus_model i_host_bus_model (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .hung(hung));

	always #10 clk = ~clk;

	// count the one-cycle action strobes
	always @(posedge clk) begin
		if (measureStart === 1'b1) nMeas++;
		if (fluxGuideStart === 1'b1) nFlux++;
		if (bitResetStart === 1'b1) nBit++;
	end

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic guard();
		if (hung !== 1'b0) begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [1:0] er = pmu_cmd_pkg::RESP_OKAY);
		logic [1:0] r;
		i_host_bus_model.wr(idx, v, r);
		guard();
		check("write resp", {30'h0, er}, {30'h0, r});
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what,
		input logic [1:0] er = pmu_cmd_pkg::RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		i_host_bus_model.rd(idx, d, r);
		guard();
		check(what, {30'h0, er}, {30'h0, r});
		if (er === pmu_cmd_pkg::RESP_OKAY) check(what, {24'h0, exp}, d);
	endtask

	// bounded wait for the command to finish
	task automatic wait_idle();
		int n;
		for (n = 0; n < 100 && cmdBusy !== 1'b0; n++) @(posedge clk);
		#2;
		if (cmdBusy !== 1'b0) begin
			failures++;
			report_and_stop();
		end
	endtask

	task automatic test_reset_map();
		rd(6'h00, {ID_HI, ID_LO}, "ident");
		rd(6'h02, 8'h00, "error");
		rd(6'h04, 8'h14, "rate");
		rd(6'h05, 8'h07, "axis");
		rd(6'h06, 8'h00, "command");
		rd(6'h07, 8'h00, "status");
		rd(6'h03, 8'h07, "pad");
		rd(6'h01, 8'h00, "unmapped", pmu_cmd_pkg::RESP_DECERR);
		wr(6'h01, 8'h55, pmu_cmd_pkg::RESP_DECERR);
		wr(6'h00, 8'h00);
		rd(6'h00, {ID_HI, ID_LO}, "ident kept");
		wr(6'h05, 8'hfd);
		rd(6'h05, 8'h05, "axis reserved");
		check("axisEnable", 32'h5, {29'h0, axisEnable});
		for (int p = 0; p < 8; p++) begin
			wr(6'h03, 8'hf8 | 8'(p));
			check("padDrive", 32'(p), {29'h0, padDrive});
		end
		rd(6'h03, 8'h07, "pad reserved");
		$display("register map test done");
	endtask

	task automatic test_overlap();
		int ef;
		ef = nFlux + 1;
		wr(6'h06, 8'h05);
		rd(6'h07, 8'h01, "busy");
		wr(6'h06, 8'h07);
		wait_idle();
		check("flux count", 32'(ef), 32'(nFlux));
		check("bit count", 32'h0, 32'(nBit));
		rd(6'h02, 8'h01, "error set");
		rd(6'h02, 8'h00, "error read clear");
		wr(6'h06, 8'h05);
		wr(6'h06, 8'h05);
		wait_idle();
		wr(6'h02, 8'h00);
		rd(6'h02, 8'h01, "error zero write");
		wr(6'h06, 8'h05);
		wr(6'h06, 8'h05);
		wait_idle();
		wr(6'h02, 8'h01);
		rd(6'h02, 8'h00, "error one write");
		$display("overlap test done");
	endtask

	// clock enable low freezes a running command
	task automatic test_freeze();
		wr(6'h06, 8'h05);
		@(posedge clk);
		clkEn <= 1'b0;
		repeat (20) @(posedge clk);
		#2;
		check("frozen busy", 32'h1, {31'h0, cmdBusy});
		@(posedge clk);
		clkEn <= 1'b1;
		wait_idle();
		$display("freeze test done");
	endtask

	task automatic test_actions();
		int em, ef, eb;
		em = nMeas;
		ef = nFlux;
		eb = nBit;
		for (logic [3:0] c = 4'h3; c <= 4'h8; c++) begin
			wr(6'h06, {4'h0, c});
			if (c < 4'h5) check("forcedMode", 32'h1, {31'h0, forcedMode});
			wait_idle();
			em += (c < 4'h5);
			ef += (c == 4'h5 || c == 4'h6);
			eb += (c > 4'h6);
			check("measures", 32'(em), 32'(nMeas));
			check("flux resets", 32'(ef), 32'(nFlux));
			check("bit resets", 32'(eb), 32'(nBit));
			check("quick", {31'h0, ~c[0]}, {31'h0, quickRecharge});
			check("mode", 32'h0, {30'h0, normalMode, forcedMode});
		end
		$display("action test done");
	endtask

	task automatic test_normal();
		int em;
		em = nMeas;
		wr(6'h06, 8'h01);
		wait_idle();
		check("normalMode", 32'h1, {31'h0, normalMode});
		rd(6'h07, 8'h08, "normal status");
		wr(6'h06, 8'h03);
		wait_idle();
		rd(6'h07, 8'h18, "illegal in normal");
		check("blocked", 32'(em), 32'(nMeas));
		wr(6'h06, 8'h09);
		wait_idle();
		rd(6'h07, 8'h18, "code 9");
		wr(6'h06, 8'h00);
		wait_idle();
		check("suspend", 32'h0, {31'h0, normalMode});
		rd(6'h07, 8'h00, "legal clears");
		wr(6'h06, 8'h0f);
		wait_idle();
		rd(6'h07, 8'h10, "code f");
		$display("normal mode test done");
	endtask

	task automatic test_rates();
		logic [3:0] o;
		for (int a = 0; a < 4; a++) begin
			o = (a == 3) ? 4'ha : 4'(2 + a);
			wr(6'h04, {2'h0, 2'(a), o});
			wr(6'h06, 8'h02);
			wait_idle();
			check("activeOdr", {28'h0, o}, {28'h0, activeOdr});
			check("avgSamples", 32'h1 << a, {28'h0, avgSamples});
			check("odrSupported", 32'h1, {31'h0, odrSupported});
			check("activeAvg", 32'(a), {30'h0, activeAvg});
			rd(6'h08, {2'h0, 2'(a), o}, "active");
			rd(6'h07, 8'h06, "overwrite status");
		end
		wr(6'h04, 8'hcb);
		rd(6'h04, 8'h0b, "rate reserved");
		wr(6'h06, 8'h02);
		wait_idle();
		check("odr unsupported", 32'h0, {31'h0, odrSupported});
		check("avg none", 32'h1, {28'h0, avgSamples});
		$display("rate test done");
	endtask

	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		test_reset_map();
		test_overlap();
		test_freeze();
		test_actions();
		test_normal();
		test_rates();
		report_and_stop();
	end
endmodule // sensor_power_command_control_tb_top
`default_nettype wire
